//--- rtl/bsfc_defines.svh
/*
 * Constants for the boot-sector flash host controller: bus timing counts,
 * command sequence addresses and data, status bit positions.
 * Assumes a 40 MHz system clock and a flash wired to the controller's pins.
 */
// What this block does
// - Host writes commands as plain write cycles
// - Unlock bypass programs with two writes
// - Busy shown by pin and toggle polling
// - Erase suspend, resume, non-erasing sectors only; the host only sends the commands and does not check the sector
// - Host places device in standby
// - Host drives separate active-low strobes, no contention
`ifndef BSFC_DEFINES_SVH
`define BSFC_DEFINES_SVH

`define BSFC_CLK_MHZ        40
`define BSFC_ACC_NS         70
`define BSFC_ACC_CYC        ((`BSFC_ACC_NS * `BSFC_CLK_MHZ + 999) / 1000)
`define BSFC_WP_NS          35
`define BSFC_WP_CYC         ((`BSFC_WP_NS * `BSFC_CLK_MHZ + 999) / 1000)
// Extra cycles for the two-stage data synchroniser
`define BSFC_SYNC_CYC       2
`define BSFC_UNLK_ADR1      19'h00555
`define BSFC_UNLK_ADR2      19'h002AA
`define BSFC_UNLK_DAT1      16'h00AA
`define BSFC_UNLK_DAT2      16'h0055
`define BSFC_CMD_PROG       16'h00A0
`define BSFC_CMD_ERASE      16'h0080
`define BSFC_CMD_CHIP       16'h0010
`define BSFC_CMD_SECT       16'h0030
`define BSFC_CMD_BYPASS     16'h0020
`define BSFC_CMD_BYP_EXIT1  16'h0090
`define BSFC_CMD_BYP_EXIT2  16'h0000
`define BSFC_CMD_SUSPEND    16'h00B0
`define BSFC_CMD_RESUME     16'h0030
`define BSFC_CMD_RESET      16'h00F0
`define BSFC_TOGGLE_BIT     6
`define BSFC_POLL_BIT       7

`endif

//--- rtl/bsfc_pkg.sv
/*
 * Types for the boot-sector flash host controller.
 * Assumes bsfc_defines.svh holds the numeric constants.
 */
package bsfc_pkg;
	// User operation codes
	typedef enum logic [3:0] {
		BSFC_OP_READ     = 4'h0,
		BSFC_OP_PROG     = 4'h1,
		BSFC_OP_CHIP_ER  = 4'h2,
		BSFC_OP_SECT_ER  = 4'h3,
		BSFC_OP_BYP_ON   = 4'h4,
		BSFC_OP_BYP_OFF  = 4'h5,
		BSFC_OP_SUSPEND  = 4'h6,
		BSFC_OP_RESUME   = 4'h7,
		BSFC_OP_RESET    = 4'h8,
		BSFC_OP_SECT_ADD = 4'h9
	} bsfc_op_t;

	// Sequencer states
	typedef enum logic [2:0] {
		BSFC_IDLE  = 3'b000,
		BSFC_WRITE = 3'b001,
		BSFC_GAP   = 3'b010,
		BSFC_READ  = 3'b011,
		BSFC_POLL  = 3'b100,
		BSFC_DONE  = 3'b101
	} bsfc_state_t;
endpackage

//--- rtl/bsfc_host.sv
/*
 * Host-side controller for a boot-sector parallel flash. Turns user
 * operations into bus write sequences and waits for completion by toggle
 * polling and the ready/busy pin.
 * Assumes the flash pins are wired directly, data lines with a resolver.
 */
`timescale 1ns/1ps
`include "bsfc_defines.svh"

module bsfc_host #(
	parameter int ADDR_W = 19,
	parameter int DATA_W = 16
) (
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst_b,
	// User request
	input  wire logic                 req_valid,
	output logic                      req_ready,
	input  wire bsfc_pkg::bsfc_op_t   req_op,
	input  wire logic [ADDR_W-1:0]    req_addr,
	input  wire logic [DATA_W-1:0]    req_data,
	input  wire logic                 word_mode,
	input  wire logic                 standby_req,
	// User answer
	output logic                      rsp_valid,
	output logic [DATA_W-1:0]         rsp_data,
	output logic                      busy,
	// Flash pins
	output logic [ADDR_W-1:0]         flash_addr,
	input  wire logic [DATA_W-1:0]    data_lines_i,
	output logic [DATA_W-1:0]         data_lines_o,
	output logic                      data_lines_oe,
	output logic                      chip_sel_n,
	output logic                      wr_strobe_n,
	output logic                      out_strobe_n,
	output logic                      byte_n,
	output logic                      flash_reset_n,
	input  wire logic                 op_done_pin_n
);
	import bsfc_pkg::*;

	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] ACC_C = CNT_W'(`BSFC_ACC_CYC);
	localparam logic [CNT_W-1:0] WP_C  = CNT_W'(`BSFC_WP_CYC);
	// Read window covers access time plus the data synchroniser
	localparam logic [CNT_W-1:0] RD_C  = ACC_C + CNT_W'(`BSFC_SYNC_CYC);

	// Sequence step: address and data
	function automatic logic [ADDR_W+DATA_W-1:0] step(
		input bsfc_op_t op, input logic [2:0] idx,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic byp,
		input logic x16);
		logic [ADDR_W-1:0] sa;
		logic [DATA_W-1:0] sd;
		sa = `BSFC_UNLK_ADR1;
		sd = `BSFC_UNLK_DAT1;
		case (idx)
			3'h1: begin
				sa = `BSFC_UNLK_ADR2;
				sd = `BSFC_UNLK_DAT2;
			end
			3'h2: sd = (op == BSFC_OP_PROG) ? 16'(`BSFC_CMD_PROG) :
				(op == BSFC_OP_BYP_ON) ? 16'(`BSFC_CMD_BYPASS) : 16'(`BSFC_CMD_ERASE);
			// Program data, or the second unlock pair of an erase
			3'h3: sd = (op == BSFC_OP_PROG) ? d : `BSFC_UNLK_DAT1;
			3'h4: sd = `BSFC_UNLK_DAT2;
			3'h5: sd = (op == BSFC_OP_CHIP_ER) ? 16'(`BSFC_CMD_CHIP) : 16'(`BSFC_CMD_SECT);
			default: ;
		endcase
		// Bypass programming: only command then data
		if (op == BSFC_OP_PROG && byp)
			sd = (idx == 3'h0) ? 16'(`BSFC_CMD_PROG) : d;
		if (op == BSFC_OP_PROG && idx == 3'h3) sa = a;
		if (op == BSFC_OP_PROG && byp && idx == 3'h1) sa = a;
		if (idx == 3'h4) sa = `BSFC_UNLK_ADR2;
		if (op == BSFC_OP_SECT_ER && idx == 3'h5) sa = a;
		if (op == BSFC_OP_SECT_ADD || op == BSFC_OP_SUSPEND || op == BSFC_OP_RESUME ||
			op == BSFC_OP_RESET || op == BSFC_OP_BYP_OFF) begin
			sa = a;
			case (op)
				BSFC_OP_SECT_ADD: sd = `BSFC_CMD_SECT;
				BSFC_OP_SUSPEND:  sd = `BSFC_CMD_SUSPEND;
				BSFC_OP_RESUME:   sd = `BSFC_CMD_RESUME;
				BSFC_OP_RESET:    sd = `BSFC_CMD_RESET;
				default:          sd = (idx == 3'h0) ? 16'(`BSFC_CMD_BYP_EXIT1) :
					16'(`BSFC_CMD_BYP_EXIT2);
			endcase
		end
		// x8 mode carries only the low lane
		if (!x16) sd = {8'h00, sd[7:0]};
		return {sa, sd};
	endfunction

	// Number of writes per operation
	function automatic logic [2:0] nwr(input bsfc_op_t op, input logic byp);
		case (op)
			BSFC_OP_PROG:     nwr = byp ? 3'h2 : 3'h4;
			BSFC_OP_CHIP_ER,
			BSFC_OP_SECT_ER:  nwr = 3'h6;
			BSFC_OP_BYP_ON:   nwr = 3'h3;
			BSFC_OP_BYP_OFF:  nwr = 3'h2;
			BSFC_OP_READ:     nwr = 3'h0;
			default:          nwr = 3'h1;
		endcase
	endfunction

	bsfc_state_t         st_q;         // Sequencer state
	bsfc_op_t            op_q;         // Latched operation
	logic [ADDR_W-1:0]   addr_q;       // Latched address
	logic [DATA_W-1:0]   data_q;       // Latched data
	logic [2:0]          idx_q;        // Write step index
	logic [CNT_W-1:0]    cnt_q;        // Pulse timer
	logic                byp_q;        // Bypass mode on
	logic                tog_q;        // Last toggle bit seen
	logic                first_q;      // First status read
	logic [1:0]          rdy_s_q;      // Ready pin synchroniser
	logic [DATA_W-1:0]   d_s1_q;       // Data sync stage one
	logic [DATA_W-1:0]   d_s2_q;       // Data sync stage two
	logic                rsp_q;        // Answer pulse
	logic [DATA_W-1:0]   rdat_q;       // Answer data
	logic [ADDR_W+DATA_W-1:0] cur;     // Current step

	assign cur = step(op_q, idx_q, addr_q, data_q, byp_q, word_mode);

	// Pin synchronisers, two stages each
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdy_s_q <= 2'b00;
			d_s1_q  <= '0;
			d_s2_q  <= '0;
		end else begin
			rdy_s_q <= {rdy_s_q[0], op_done_pin_n};
			d_s1_q  <= data_lines_i;
			d_s2_q  <= d_s1_q;
		end
	end

	// Main sequencer
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_q    <= BSFC_IDLE;
			op_q    <= BSFC_OP_READ;
			addr_q  <= '0;
			data_q  <= '0;
			idx_q   <= 3'h0;
			cnt_q   <= '0;
			byp_q   <= 1'b0;
			tog_q   <= 1'b0;
			first_q <= 1'b0;
			rsp_q   <= 1'b0;
			rdat_q  <= '0;
		end else begin
			rsp_q <= 1'b0;
			case (st_q)
				BSFC_IDLE: begin
					if (req_valid) begin
						op_q   <= req_op;
						addr_q <= req_addr;
						data_q <= req_data;
						idx_q  <= 3'h0;
						cnt_q  <= (req_op == BSFC_OP_READ) ? RD_C : WP_C;
						st_q   <= (req_op == BSFC_OP_READ) ? BSFC_READ : BSFC_WRITE;
					end
				end
				// Write strobe low for the pulse width
				BSFC_WRITE: begin
					if (cnt_q <= 4'h1) begin
						cnt_q <= WP_C;
						st_q  <= BSFC_GAP;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				// Strobe high between writes
				BSFC_GAP: begin
					if (cnt_q <= 4'h1) begin
						if (idx_q + 3'h1 >= nwr(op_q, byp_q)) begin
							if (op_q == BSFC_OP_BYP_ON) byp_q <= 1'b1;
							if (op_q == BSFC_OP_BYP_OFF || op_q == BSFC_OP_RESET) byp_q <= 1'b0;
							first_q <= 1'b1;
							cnt_q   <= RD_C;
							// Program and erase run inside the flash; wait for it
							st_q <= (op_q == BSFC_OP_PROG || op_q == BSFC_OP_CHIP_ER ||
								op_q == BSFC_OP_SECT_ER || op_q == BSFC_OP_RESUME) ?
								BSFC_POLL : BSFC_DONE;
						end else begin
							idx_q <= idx_q + 3'h1;
							cnt_q <= WP_C;
							st_q  <= BSFC_WRITE;
						end
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				// Array read, output strobe held for access time
				BSFC_READ: begin
					if (cnt_q <= 4'h1) begin
						rdat_q <= word_mode ? d_s2_q : {8'h00, d_s2_q[7:0]};
						st_q   <= BSFC_DONE;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				// Toggle polling; two equal reads with ready pin high mean done
				BSFC_POLL: begin
					if (cnt_q <= 4'h1) begin
						tog_q   <= d_s2_q[`BSFC_TOGGLE_BIT];
						first_q <= 1'b0;
						cnt_q   <= RD_C;
						if (!first_q && tog_q == d_s2_q[`BSFC_TOGGLE_BIT] && rdy_s_q[1]) begin
							rdat_q <= d_s2_q;
							st_q   <= BSFC_DONE;
						end
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				BSFC_DONE: begin
					rsp_q <= 1'b1;
					st_q  <= BSFC_IDLE;
				end
				default: st_q <= BSFC_IDLE;
			endcase
		end
	end

	// Pin drive; strobes never overlap, data driven only while writing
	always_comb begin
		flash_addr    = (st_q == BSFC_WRITE || st_q == BSFC_GAP) ?
			cur[ADDR_W+DATA_W-1:DATA_W] : addr_q;
		data_lines_o  = cur[DATA_W-1:0];
		data_lines_oe = (st_q == BSFC_WRITE || st_q == BSFC_GAP);
		wr_strobe_n   = !(st_q == BSFC_WRITE);
		out_strobe_n  = !((st_q == BSFC_READ || st_q == BSFC_POLL) && cnt_q > 4'h1);
		// Standby when idle and asked for
		chip_sel_n    = (st_q == BSFC_IDLE) && standby_req;
	end

	assign byte_n        = word_mode;
	assign flash_reset_n = rst_b;
	assign req_ready     = (st_q == BSFC_IDLE);
	assign rsp_valid     = rsp_q;
	assign rsp_data      = rdat_q;
	assign busy          = (st_q != BSFC_IDLE);
endmodule

//--- tb/bsfc_host_asserts.sv
/* Pin-level checker for the flash host controller.
   Assumes it is bound to bsfc_host and sees only its ports. */
`timescale 1ns/1ps
module bsfc_host_asserts #(
	parameter int ADDR_W = 19,
	parameter int DATA_W = 16
) (
	// Clock, reset and user side
	input wire logic              clk_sys,
	input wire logic              rst_b,
	input wire logic              req_valid,
	input wire logic              req_ready,
	input wire logic              busy,
	input wire logic              standby_req,
	// Flash pins
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic [DATA_W-1:0] data_lines_o,
	input wire logic              data_lines_oe,
	input wire logic              chip_sel_n,
	input wire logic              wr_strobe_n,
	input wire logic              out_strobe_n
);
	// One domain, so one clock and one disable
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	a_no_bus_fight: assert property (!out_strobe_n |-> !data_lines_oe)
		else $error("host drives data while flash outputs");
	a_strobe_excl: assert property (!(!wr_strobe_n && !out_strobe_n))
		else $error("write and output strobes both low");
	a_write_qual: assert property (!wr_strobe_n |-> !chip_sel_n && data_lines_oe)
		else $error("write strobe without select or data");
	a_write_pulse: assert property ($fell(wr_strobe_n) |=> !wr_strobe_n ##1 wr_strobe_n)
		else $error("write pulse not two cycles");
	a_write_hold: assert property (!wr_strobe_n && !$past(wr_strobe_n)
		|-> $stable(flash_addr) && $stable(data_lines_o))
		else $error("address or data moved in write pulse");
	a_idle_quiet: assert property (!busy |-> wr_strobe_n && out_strobe_n)
		else $error("strobe active while idle");
	a_standby_sel: assert property (!busy && standby_req |-> chip_sel_n)
		else $error("chip selected in standby");
	a_take_busy: assert property (req_valid && req_ready |=> busy)
		else $error("taken request left host idle");
endmodule
bind bsfc_host bsfc_host_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
	.clk_sys, .rst_b, .req_valid, .req_ready, .busy, .standby_req, .flash_addr,
	.data_lines_o, .data_lines_oe, .chip_sel_n, .wr_strobe_n, .out_strobe_n);

//--- tb/bsfc_flash_model.sv
/* Behavioural flash: command decode, tiny array, busy pin, toggle bit.
   Assumes pins sampled on the host clock; 16-word sectors. */
`timescale 1ns/1ps
module bsfc_flash_model (
	// Clock and pins
	input wire logic        clk,
	input wire logic        cs_n,
	input wire logic        we_n,
	input wire logic        oe_n,
	input wire logic        rst_n,
	input wire logic        byte_n,
	input wire logic [18:0] a,
	input wire logic [15:0] d,
	output logic [15:0]     dq,
	output logic            op_done_pin_n
);
	logic [15:0] mem [0:255]; // Erased array
	logic [15:0] wd;
	logic [7:0]  wa;
	logic [2:0]  st;
	logic        byp, wl, tg, rd;
	int          bc, wr_cnt;
	logic [15:0] prot       = '0;   // Protected 16-word sectors
	logic        tmp_unprot = 1'b0; // Temporary unprotect active
	logic        low_vcc    = 1'b0; // Supply detector tripped
	assign op_done_pin_n = (bc == 0);
	initial begin
		foreach (mem[i]) mem[i] = 16'hFFFF;
		{st, byp, wl, tg, rd, bc, wr_cnt, dq} = '0;
	end
	// Writes act when the strobe rises; reset pin aborts
	always @(posedge clk) begin
		if (!rst_n) begin
			st <= 0;
			wl <= 0;
			bc <= 0;
		end else if (!cs_n && !we_n && !low_vcc) begin
			{wl, wa, wd} <= {1'b1, a[7:0], d};
		end else if (wl) begin
			wl <= 0;
			wr_cnt <= wr_cnt + 1;
			if (wd[7:0] == 8'hF0) st <= 0;
			else case (st)
				0: st <= byp && wd[7:0] == 8'hA0 ? 3 : byp && wd[7:0] == 8'h90 ? 7 :
					wd[7:0] == 8'hAA ? 1 : 0;
				1: st <= wd[7:0] == 8'h55 ? 2 : 0;
				2: begin
					st <= wd[7:0] == 8'hA0 ? 3 : wd[7:0] == 8'h80 ? 4 : 0;
					if (wd[7:0] == 8'h20) byp <= 1;
				end
				3: begin
					if (tmp_unprot || !prot[wa[7:4]])
						mem[wa] <= mem[wa] & wd;
					bc <= 20;
					st <= 0;
				end
				4: st <= wd[7:0] == 8'hAA ? 5 : 0;
				5: st <= wd[7:0] == 8'h55 ? 6 : 0;
				6: begin
					foreach (mem[i]) if ((wd[7:0] == 8'h10 || i[7:4] == wa[7:4]) &&
						(tmp_unprot || !prot[i[7:4]]))
						mem[i] <= 16'hFFFF;
					bc <= 40;
					st <= 0;
				end
				default: begin
					if (wd[7:0] == 8'h00) byp <= 0;
					st <= 0;
				end
			endcase
		end else if (bc > 0) bc <= bc - 1;
	end
	// Status while busy, array otherwise; released lines show the inverse
	always @(posedge clk) begin
		rd <= !cs_n && !oe_n;
		if (rd && oe_n) tg <= !tg;
		if (!cs_n && !oe_n)
			dq <= bc ? {9'h000, tg, 6'h00} : byte_n ? mem[a[7:0]] :
				{~mem[a[7:0]][15:8], mem[a[7:0]][7:0]};
		else dq <= ~dq;
	end
endmodule

//--- tb/bsfc_host_tb.sv
/* Self-checking bench for bsfc_host against the flash model.
   Assumes the design files compile first. */
`timescale 1ns/1ps
`define CHK(x, y) begin cmp_count++; if ((x) !== (y)) begin error_cnt++; \
	$display("ERROR %0t mismatch %h %h", $time, x, y); end end
module bsfc_host_tb;
	import bsfc_pkg::*;
	logic clk_sys = 0, rst_b = 0, req_valid = 0, word_mode = 1, standby_req = 0;
	logic [18:0] req_addr = '0, flash_addr;
	logic [15:0] req_data = '0, rsp_data, dlo, m_dq, dq, r;
	bsfc_op_t req_op = BSFC_OP_READ;
	logic req_ready, rsp_valid, busy, oe, cs_n, we_n, oe_n, byte_n, frst_n, done_n;
	int error_cnt = 0, cmp_count = 0, w0;
	assign dq = oe ? dlo : m_dq; // Data line resolver
	always #12.5 clk_sys = ~clk_sys;
	bsfc_host i_dut (.clk_sys, .rst_b, .req_valid, .req_ready, .req_op, .req_addr,
		.req_data, .word_mode, .standby_req, .rsp_valid, .rsp_data, .busy,
		.flash_addr, .data_lines_i(dq), .data_lines_o(dlo), .data_lines_oe(oe),
		.chip_sel_n(cs_n), .wr_strobe_n(we_n), .out_strobe_n(oe_n), .byte_n,
		.flash_reset_n(frst_n), .op_done_pin_n(done_n));
	bsfc_flash_model i_mdl (.clk(clk_sys), .cs_n, .we_n, .oe_n, .rst_n(frst_n),
		.byte_n, .a(flash_addr), .d(dlo), .dq(m_dq), .op_done_pin_n(done_n));
	task tally_and_finish;
		if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// One user operation, bounded wait for the answer
	task do_op(input bsfc_op_t op, input logic [18:0] ad, input logic [15:0] da);
		int n;
		n = 0;
		while (req_ready !== 1'b1) @(negedge clk_sys);
		req_op    = op;
		req_addr  = ad;
		req_data  = da;
		req_valid = 1'b1;
		@(negedge clk_sys) req_valid = 0;
		while (rsp_valid !== 1'b1 && n < 4000) begin
			@(negedge clk_sys);
			n++;
		end
		r = rsp_data;
		`CHK(n < 4000, 1'b1)
	endtask
	task t_prog;
		w0 = i_mdl.wr_cnt;
		do_op(BSFC_OP_PROG, 19'h00010, 16'h1234);
		`CHK(i_mdl.wr_cnt - w0, 4)
		`CHK(done_n, 1'b1)
		do_op(BSFC_OP_READ, 19'h00010, 16'h0000);
		`CHK(r, 16'h1234)
		do_op(BSFC_OP_PROG, 19'h00010, 16'h0F0F);
		do_op(BSFC_OP_READ, 19'h00010, 16'h0000);
		`CHK(r, 16'h0204)
	endtask
	task t_bypass;
		do_op(BSFC_OP_BYP_ON, 19'h0, 16'h0);
		w0 = i_mdl.wr_cnt;
		do_op(BSFC_OP_PROG, 19'h00020, 16'h00FF);
		`CHK(i_mdl.wr_cnt - w0, 2)
		do_op(BSFC_OP_BYP_OFF, 19'h0, 16'h0);
		do_op(BSFC_OP_READ, 19'h00020, 16'h0000);
		`CHK(r, 16'h00FF)
	endtask
	task t_erase;
		do_op(BSFC_OP_SECT_ER, 19'h00010, 16'h0);
		do_op(BSFC_OP_READ, 19'h00010, 16'h0);
		`CHK(r, 16'hFFFF)
		do_op(BSFC_OP_READ, 19'h00020, 16'h0);
		`CHK(r, 16'h00FF)
		do_op(BSFC_OP_CHIP_ER, 19'h0, 16'h0);
		do_op(BSFC_OP_READ, 19'h00020, 16'h0);
		`CHK(r, 16'hFFFF)
	endtask
	task t_byte_standby;
		do_op(BSFC_OP_PROG, 19'h00030, 16'hA55A);
		word_mode = 0;
		do_op(BSFC_OP_READ, 19'h00030, 16'h0);
		`CHK(r, 16'h005A)
		`CHK(byte_n, 1'b0)
		word_mode = 1;
		standby_req = 1;
		@(negedge clk_sys);
		`CHK(cs_n, 1'b1)
		standby_req = 0;
	endtask
	// Protected sector, temporary unprotect, low supply
	task t_protect;
		i_mdl.prot[4] = 1'b1;
		do_op(BSFC_OP_PROG, 19'h00040, 16'h0000);
		do_op(BSFC_OP_READ, 19'h00040, 16'h0);
		`CHK(r, 16'hFFFF)
		i_mdl.tmp_unprot = 1'b1;
		do_op(BSFC_OP_PROG, 19'h00040, 16'h0000);
		do_op(BSFC_OP_READ, 19'h00040, 16'h0);
		`CHK(r, 16'h0000)
		i_mdl.tmp_unprot = 1'b0;
		i_mdl.low_vcc = 1'b1;
		do_op(BSFC_OP_PROG, 19'h00050, 16'h0000);
		i_mdl.low_vcc = 1'b0;
		do_op(BSFC_OP_READ, 19'h00050, 16'h0);
		`CHK(r, 16'hFFFF)
	endtask
	// Single-write commands reach the flash with their codes
	task t_cmds;
		w0 = i_mdl.wr_cnt;
		do_op(BSFC_OP_SUSPEND, 19'h00010, 16'h0);
		`CHK(i_mdl.wd, 16'h00B0)
		do_op(BSFC_OP_RESUME, 19'h00010, 16'h0);
		`CHK(i_mdl.wd, 16'h0030)
		do_op(BSFC_OP_SECT_ADD, 19'h00010, 16'h0);
		`CHK(i_mdl.wd, 16'h0030)
		do_op(BSFC_OP_RESET, 19'h0, 16'h0);
		`CHK(i_mdl.wd, 16'h00F0)
		`CHK(i_mdl.wr_cnt - w0, 4)
	endtask
	// Reset in the middle of a chip erase sequence
	task t_reset;
		req_op    = BSFC_OP_CHIP_ER;
		req_addr  = '0;
		req_data  = '0;
		req_valid = 1'b1;
		@(negedge clk_sys) req_valid = 0;
		repeat (17) @(negedge clk_sys);
		rst_b = 0;
		@(negedge clk_sys);
		`CHK(busy, 1'b0)
		`CHK(frst_n, 1'b0)
		rst_b = 1;
		`CHK(done_n, 1'b1)
		do_op(BSFC_OP_READ, 19'h00030, 16'h0);
		`CHK(r, 16'hA55A)
	endtask
	// Watchdog sized well above the expected run
	initial begin
		#1000000;
		error_cnt++;
		tally_and_finish;
	end
	initial begin
		repeat (8) @(negedge clk_sys);
		rst_b = 1;
		t_prog;
		t_bypass;
		t_erase;
		t_protect;
		t_cmds;
		t_byte_standby;
		t_reset;
		tally_and_finish;
	end
endmodule
